// [rtl/adcdc_filt.sv]
// Sinc averager and low-pass IIR core of the DC meter.
// Assumes one ADC modulator tick per valid sample, clock-enable held.
`timescale 1ns/1ps

module adcdc_filt
  import adcdc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // Configuration and samples
  input  wire adcdc_cfg_t  cfg,
  input  wire adcdc_smp_t  smp,
  // Presented result
  output logic [23:0]      result_ff
);

  adcdc_mode_t                    mode_ff,   nxt_mode;
  logic signed [`ADCDC_ACC_W-1:0] acc_ff,    nxt_acc;
  logic [`ADCDC_CNT_W-1:0]        cnt_ff,    nxt_cnt;
  logic [23:0]                    snap_ff,   nxt_snap;
  logic [23:0]                    nxt_result;
  logic signed [`ADCDC_ACC_W-1:0] sum_c;
  logic signed [`ADCDC_ACC_W-1:0] iir_c;
  logic [23:0]                    inst_c;
  logic                           wrap_c;

  always_comb begin
    sum_c  = acc_ff + `ADCDC_ACC_W'(smp.data);
    iir_c  = sum_c - `ADCDC_ACC_W'($signed(adcdc_shr(acc_ff, cfg.exp_d)));
    inst_c = adcdc_shr(iir_c, cfg.exp_d);
    wrap_c = 1'b0;
    nxt_mode   = !cfg.en ? ADCDC_IDLE : cfg.iir ? ADCDC_IIR : ADCDC_SINC;
    nxt_acc    = acc_ff;
    nxt_cnt    = cnt_ff;
    nxt_snap   = snap_ff;
    nxt_result = result_ff;
    case (mode_ff)
      ADCDC_SINC: begin
        if (smp.valid) begin
          if (cnt_ff == adcdc_last(cfg.exp_d)) begin
            nxt_acc = '0;
            nxt_cnt = '0;
            if (!cfg.hold) begin
              nxt_result = adcdc_shr(sum_c, cfg.exp_d);
            end
          end else begin
            nxt_acc = sum_c;
            nxt_cnt = cnt_ff + 1'b1;
          end
        end
      end
      ADCDC_IIR: begin
        if (smp.valid) begin
          nxt_acc = iir_c;
          if (cfg.avg != 5'h00) begin
            wrap_c  = (cnt_ff == adcdc_last(cfg.avg));
            nxt_cnt = wrap_c ? '0 : cnt_ff + 1'b1;
          end else begin
            nxt_cnt = '0;
          end
          if (wrap_c) begin
            nxt_snap = inst_c;
            nxt_acc  = '0;
          end
          if (!cfg.hold) begin
            nxt_result = cfg.osel ? nxt_snap : inst_c;
          end
        end
      end
      default: begin
        nxt_acc = '0;
        nxt_cnt = '0;
      end
    endcase
    if (nxt_mode != mode_ff) begin
      nxt_acc = '0;
      nxt_cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_ff   <= ADCDC_IDLE;
      acc_ff    <= '0;
      cnt_ff    <= '0;
      snap_ff   <= `ADCDC_RES_RST;
      result_ff <= `ADCDC_RES_RST;
    end else if (ce) begin
      mode_ff   <= nxt_mode;
      acc_ff    <= nxt_acc;
      cnt_ff    <= nxt_cnt;
      snap_ff   <= nxt_snap;
      result_ff <= nxt_result;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence held_two;
    cfg.hold ##1 cfg.hold;
  endsequence

  hold_freeze_a: assert property (held_two |-> $stable(result_ff))
    else $error("result moved while hold set");
  idle_clear_a: assert property (ce && !cfg.en |=> acc_ff == '0 && cnt_ff == '0)
    else $error("filter state not cleared while disabled");
  sinc_block_a: assert property (
    ce && mode_ff == ADCDC_SINC && smp.valid && !cfg.hold &&
    cfg.en && !cfg.iir && cnt_ff == adcdc_last(cfg.exp_d)
    |=> result_ff == $past(adcdc_shr(sum_c, cfg.exp_d)))
    else $error("sinc block result wrong");
  iir_wrap_a: assert property (
    ce && mode_ff == ADCDC_IIR && cfg.en && cfg.iir && smp.valid &&
    cfg.avg != 5'h00 && cnt_ff == adcdc_last(cfg.avg)
    |=> acc_ff == '0 && snap_ff == $past(inst_c))
    else $error("iir not cleared at end of window");
  iir_inst_a: assert property (
    ce && mode_ff == ADCDC_IIR && smp.valid && !cfg.hold && !cfg.osel
    |=> result_ff == $past(inst_c))
    else $error("instantaneous iir output not presented");
  infinite_avg_a: assert property (
    mode_ff == ADCDC_IIR && cfg.avg == 5'h00 && $past(cfg.avg) == 5'h00 &&
    $past(mode_ff) == ADCDC_IIR |-> cnt_ff == '0)
    else $error("window counter runs under infinite average");

endmodule

// [rtl/adcdc_pkg.sv]
// Types and shared arithmetic of the DC meter.
// Assumes adcdc_regs.svh on the include path.
`include "adcdc_regs.svh"

package adcdc_pkg;

  typedef struct packed {
    logic       en;
    logic       iir;
    logic [4:0] exp_d;
    logic       hold;
    logic       osel;
    logic [4:0] avg;
  } adcdc_cfg_t;

  typedef struct packed {
    logic               valid;
    logic signed [23:0] data;
  } adcdc_smp_t;

  typedef enum logic [1:0] {
    ADCDC_IDLE,
    ADCDC_SINC,
    ADCDC_IIR
  } adcdc_mode_t;

  // Arithmetic shift of the accumulator, cut to the 24-bit result
  function automatic logic [23:0] adcdc_shr(
    input logic signed [`ADCDC_ACC_W-1:0] a,
    input logic [4:0]                     e
  );
    logic signed [`ADCDC_ACC_W-1:0] t;
    t = a >>> e;
    return t[23:0];
  endfunction

  // Last count of a 2^e window, e kept inside 1..20
  function automatic logic [`ADCDC_CNT_W-1:0] adcdc_last(
    input logic [4:0] e
  );
    logic [4:0]              k;
    logic [`ADCDC_CNT_W-1:0] one;
    k   = (e < `ADCDC_EXP_MIN) ? `ADCDC_EXP_MIN :
          (e > `ADCDC_EXP_MAX) ? `ADCDC_EXP_MAX : e;
    one = `ADCDC_CNT_W'(1);
    return (one << k) - one;
  endfunction

endpackage

// [rtl/adcdc_regs.svh]
// Register map, field positions, reset values and limits of the DC meter.
// Assumes 7-bit register addresses on an 8-bit paged register port.
`ifndef ADCDC_REGS_SVH
`define ADCDC_REGS_SVH

// Register addresses
`define ADCDC_PAGE_ADDR   7'h00
`define ADCDC_AGC_ADDR    7'h5D
`define ADCDC_RSV_LO_ADDR 7'h5E
`define ADCDC_RSV_HI_ADDR 7'h65
`define ADCDC_CTL1_ADDR   7'h66
`define ADCDC_CTL2_ADDR   7'h67
`define ADCDC_RES_HI_ADDR 7'h68
`define ADCDC_RES_MD_ADDR 7'h69
`define ADCDC_RES_LO_ADDR 7'h6A

// Page holding these registers
`define ADCDC_DC_PAGE     8'h00

// Field positions
`define ADCDC_EN_BIT      7
`define ADCDC_IIR_BIT     5
`define ADCDC_HOLD_BIT    6
`define ADCDC_OSEL_BIT    5
`define ADCDC_EXP_MSB     4

// Reset values
`define ADCDC_PAGE_RST    8'h00
`define ADCDC_CTL1_RST    8'h00
`define ADCDC_CTL2_RST    8'h00
`define ADCDC_RES_RST     24'h000000
`define ADCDC_AGC_RST     8'h00

// Limits
`define ADCDC_AGC_MIN     8'hE8
`define ADCDC_AGC_MAX     8'h77
`define ADCDC_EXP_MIN     5'h01
`define ADCDC_EXP_MAX     5'h14
`define ADCDC_ACC_W       44
`define ADCDC_CNT_W       21

`endif

// [rtl/adcdc_top.sv]
// DC level meter of the mono record channel with AGC gain readout.
// Assumes a synchronous 8-bit paged register port and one ADC sample
// strobe per modulator clock period, all on clk.
`timescale 1ns/1ps

module adcdc_top
  import adcdc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               ce,
  // Register port
  input  wire logic [6:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [7:0]              reg_rdata_ff,
  // Record channel
  input  wire logic               adc_valid,
  input  wire logic signed [23:0] adc_data,
  input  wire logic [7:0]         agc_gain,
  // Status
  output logic                    dc_active_ff
);

  logic [7:0]  page_ff,   nxt_page;
  logic [7:0]  ctl1_ff,   nxt_ctl1;
  logic [7:0]  ctl2_ff,   nxt_ctl2;
  logic [7:0]  agc_ff,    nxt_agc;
  logic [7:0]  nxt_rdata;
  logic        nxt_active;
  logic [23:0] result;
  logic        on_page_c;
  adcdc_cfg_t  cfg;
  adcdc_smp_t  smp;

  // Configuration carried to the filter core
  always_comb begin
    cfg.en    = ctl1_ff[`ADCDC_EN_BIT];
    cfg.iir   = ctl1_ff[`ADCDC_IIR_BIT];
    cfg.exp_d = ctl1_ff[`ADCDC_EXP_MSB:0];
    cfg.hold  = ctl2_ff[`ADCDC_HOLD_BIT];
    cfg.osel  = ctl2_ff[`ADCDC_OSEL_BIT];
    cfg.avg   = ctl2_ff[`ADCDC_EXP_MSB:0];
    smp.valid = adc_valid;
    smp.data  = adc_data;
  end

  adcdc_filt u_filt (
    .clk       (clk),
    .resetn    (resetn),
    .ce        (ce),
    .cfg       (cfg),
    .smp       (smp),
    .result_ff (result)
  );

  // Page select and control writes
  always_comb begin
    on_page_c = (page_ff == `ADCDC_DC_PAGE);
    nxt_page  = page_ff;
    nxt_ctl1  = ctl1_ff;
    nxt_ctl2  = ctl2_ff;
    if (reg_wr) begin
      if (reg_addr == `ADCDC_PAGE_ADDR) begin
        nxt_page = reg_wdata;
      end else if (on_page_c) begin
        case (reg_addr)
          `ADCDC_CTL1_ADDR: nxt_ctl1 = reg_wdata;
          `ADCDC_CTL2_ADDR: nxt_ctl2 = reg_wdata;
          default: begin
            nxt_ctl1 = ctl1_ff;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      page_ff <= `ADCDC_PAGE_RST;
      ctl1_ff <= `ADCDC_CTL1_RST;
      ctl2_ff <= `ADCDC_CTL2_RST;
    end else if (ce) begin
      page_ff <= nxt_page;
      ctl1_ff <= nxt_ctl1;
      ctl2_ff <= nxt_ctl2;
    end
  end

  // AGC gain capture, clamped to the readable span
  always_comb begin
    if ($signed(agc_gain) < $signed(`ADCDC_AGC_MIN)) begin
      nxt_agc = `ADCDC_AGC_MIN;
    end else if ($signed(agc_gain) > $signed(`ADCDC_AGC_MAX)) begin
      nxt_agc = `ADCDC_AGC_MAX;
    end else begin
      nxt_agc = agc_gain;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      agc_ff <= `ADCDC_AGC_RST;
    end else if (ce) begin
      agc_ff <= nxt_agc;
    end
  end

  // Read data and status
  always_comb begin
    nxt_rdata  = reg_rdata_ff;
    nxt_active = cfg.en;
    if (reg_rd) begin
      if (reg_addr == `ADCDC_PAGE_ADDR) begin
        nxt_rdata = page_ff;
      end else if (!on_page_c) begin
        nxt_rdata = 8'h00;
      end else begin
        case (reg_addr)
          `ADCDC_AGC_ADDR:    nxt_rdata = agc_ff;
          `ADCDC_CTL1_ADDR:   nxt_rdata = ctl1_ff;
          `ADCDC_CTL2_ADDR:   nxt_rdata = ctl2_ff;
          `ADCDC_RES_HI_ADDR: nxt_rdata = result[23:16];
          `ADCDC_RES_MD_ADDR: nxt_rdata = result[15:8];
          `ADCDC_RES_LO_ADDR: nxt_rdata = result[7:0];
          default:            nxt_rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata_ff <= 8'h00;
      dc_active_ff <= 1'b0;
    end else if (ce) begin
      reg_rdata_ff <= nxt_rdata;
      dc_active_ff <= nxt_active;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence page_zero_read(logic [6:0] a);
    ce && reg_rd && page_ff == `ADCDC_DC_PAGE && reg_addr == a;
  endsequence

  sequence ctl_write_blocked;
    ce && reg_wr && page_ff != `ADCDC_DC_PAGE &&
    (reg_addr == `ADCDC_CTL1_ADDR || reg_addr == `ADCDC_CTL2_ADDR);
  endsequence

  agc_range_a: assert property (
    $signed(agc_ff) >= $signed(`ADCDC_AGC_MIN) &&
    $signed(agc_ff) <= $signed(`ADCDC_AGC_MAX))
    else $error("agc readout outside its span");
  agc_track_a: assert property (
    ce && $signed(agc_gain) >= $signed(`ADCDC_AGC_MIN) &&
    $signed(agc_gain) <= $signed(`ADCDC_AGC_MAX)
    |=> agc_ff == $past(agc_gain))
    else $error("agc readout does not follow applied gain");
  agc_read_a: assert property (
    page_zero_read(`ADCDC_AGC_ADDR) |=> reg_rdata_ff == $past(agc_ff))
    else $error("agc register read wrong");
  page_write_a: assert property (
    ce && reg_wr && reg_addr == `ADCDC_PAGE_ADDR
    |=> page_ff == $past(reg_wdata))
    else $error("page register not written");
  ctl_blocked_a: assert property (
    ctl_write_blocked |=> $stable(ctl1_ff) && $stable(ctl2_ff))
    else $error("control written from another page");
  res_high_a: assert property (
    page_zero_read(`ADCDC_RES_HI_ADDR)
    |=> reg_rdata_ff == $past(result[23:16]))
    else $error("result high byte read wrong");
  res_low_a: assert property (
    page_zero_read(`ADCDC_RES_LO_ADDR)
    |=> reg_rdata_ff == $past(result[7:0]))
    else $error("result low byte read wrong");
  active_follow_a: assert property (
    ce && reg_wr && page_ff == `ADCDC_DC_PAGE &&
    reg_addr == `ADCDC_CTL1_ADDR ##1 ce
    |=> dc_active_ff == $past(reg_wdata[`ADCDC_EN_BIT], 2))
    else $error("active flag does not follow enable bit");

endmodule

// [tb/tb_adcdc_top.sv]
// Self-checking bench of the DC meter top: register port tasks, samples.
// Assumes adcdc_pkg and adcdc_regs.svh compiled ahead of this file.
`timescale 1ns/1ps
`include "adcdc_regs.svh"

module tb_adcdc_top;
  import adcdc_pkg::*;

  logic               clk = 1'b0;
  logic               resetn = 1'b0;
  logic               ce = 1'b1;
  logic [6:0]         reg_addr = 7'h00;
  logic [7:0]         reg_wdata = 8'h00;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [7:0]         reg_rdata_ff;
  logic               adc_valid = 1'b0;
  logic signed [23:0] adc_data = 24'h000000;
  logic [7:0]         agc_gain = 8'h00;
  logic               dc_active_ff;
  int                 n_errors = 0;
  int                 n_tests = 0;
  logic [6:0]         ra [6] = '{7'h66, 7'h67, 7'h68, 7'h69, 7'h6A, 7'h5D};
  logic [7:0]         ga [6] = '{8'hE8, 8'hF0, 8'h00, 8'h77, 8'h80, 8'h7F};
  logic [7:0]         ge [6] = '{8'hE8, 8'hF0, 8'h00, 8'h77, 8'hE8, 8'h77};

  always #5 clk = ~clk;

  adcdc_top u_dut (
    .clk          (clk),
    .resetn       (resetn),
    .ce           (ce),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata_ff (reg_rdata_ff),
    .adc_valid    (adc_valid),
    .adc_data     (adc_data),
    .agc_gain     (agc_gain),
    .dc_active_ff (dc_active_ff)
  );

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask

  // All tasks start and end 1 ns after a rising edge
  // Idle edge after each strobe keeps back-to-back calls apart
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    tick();
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata_ff;
    tick();
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk({16'h0000, d}, {16'h0000, e});
  endtask

  // Reads the three result bytes, high first
  task automatic rres(input logic [23:0] e);
    logic [7:0] h;
    logic [7:0] m;
    logic [7:0] l;
    rd(`ADCDC_RES_HI_ADDR, h);
    rd(`ADCDC_RES_MD_ADDR, m);
    rd(`ADCDC_RES_LO_ADDR, l);
    chk({h, m, l}, e);
  endtask

  task automatic smp(input logic signed [23:0] x);
    adc_valid = 1'b1;
    adc_data = x;
    @(posedge clk);
    #1;
    adc_valid = 1'b0;
    tick();
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rchk(ra[i], 8'h00);
    end
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      agc_gain = ga[i];
      tick();
      rchk(`ADCDC_AGC_ADDR, ge[i]);
    end
    $display("test agc done");
    wr(`ADCDC_CTL1_ADDR, 8'h85);
    tick();
    chk({23'h0, dc_active_ff}, 24'h000001);
    rchk(`ADCDC_CTL1_ADDR, 8'h85);
    wr(`ADCDC_CTL2_ADDR, 8'h74);
    rchk(`ADCDC_CTL2_ADDR, 8'h74);
    rchk(7'h60, 8'h00);
    wr(`ADCDC_RES_HI_ADDR, 8'hFF);
    rchk(`ADCDC_RES_HI_ADDR, 8'h00);
    wr(`ADCDC_CTL2_ADDR, 8'h00);
    wr(`ADCDC_PAGE_ADDR, 8'h01);
    rchk(`ADCDC_CTL1_ADDR, 8'h00);
    wr(`ADCDC_CTL1_ADDR, 8'h00);
    rchk(`ADCDC_PAGE_ADDR, 8'h01);
    wr(`ADCDC_PAGE_ADDR, 8'h00);
    rchk(`ADCDC_CTL1_ADDR, 8'h85);
    $display("test registers done");
    wr(`ADCDC_CTL1_ADDR, 8'h81);
    smp(24'sd100);
    smp(24'sd300);
    rres(24'd200);
    wr(`ADCDC_CTL1_ADDR, 8'h82);
    smp(-24'sd8);
    smp(-24'sd4);
    smp(-24'sd2);
    smp(-24'sd2);
    rres(24'hFFFFFC);
    $display("test sinc done");
    wr(`ADCDC_CTL1_ADDR, 8'h81);
    smp(24'sd10);
    smp(24'sd30);
    rres(24'd20);
    wr(`ADCDC_CTL2_ADDR, 8'h40);
    smp(24'sd50);
    smp(24'sd70);
    rres(24'd20);
    wr(`ADCDC_CTL2_ADDR, 8'h00);
    smp(24'sd2);
    smp(24'sd4);
    rres(24'd3);
    $display("test hold done");
    smp(24'sd1000);
    wr(`ADCDC_CTL1_ADDR, 8'h01);
    tick();
    chk({23'h0, dc_active_ff}, 24'h000000);
    wr(`ADCDC_CTL1_ADDR, 8'h81);
    smp(24'sd6);
    smp(24'sd8);
    rres(24'd7);
    $display("test disable done");
    wr(`ADCDC_CTL1_ADDR, 8'hA1);
    smp(24'sd1000);
    rres(24'd500);
    smp(24'sd1000);
    rres(24'd750);
    wr(`ADCDC_CTL1_ADDR, 8'h01);
    wr(`ADCDC_CTL2_ADDR, 8'h21);
    wr(`ADCDC_CTL1_ADDR, 8'hA1);
    smp(24'sd1000);
    rres(24'd0);
    smp(24'sd1000);
    rres(24'd750);
    smp(24'sd1000);
    smp(24'sd1000);
    rres(24'd750);
    ce = 1'b0;
    wr(`ADCDC_CTL1_ADDR, 8'h01);
    ce = 1'b1;
    rchk(`ADCDC_CTL1_ADDR, 8'hA1);
    $display("test iir done");
    close_out();
  end
endmodule
